// [src/esrd_pkg.sv]
package esrd_pkg;

   // Widths of the read path
   localparam int PTR_W        = 16;
   localparam int PAGE_W       = 10;
   localparam int ADDR_W       = 24;
   localparam int OFS_W        = 15;
   localparam int PAGE_LOW_W   = 9;
   localparam int PAD_W        = ADDR_W - PTR_W;

   // Field positions
   localparam int PTR_TOP_BIT  = 15;
   localparam int PAGE_HI_BIT  = 9;

   // Upper address bits of an ordinary data-space read
   localparam logic [PAD_W-1:0] PLAIN_PAD = 8'h00;

   // Reset values
   localparam logic              READY_RST = 1'b1;
   localparam logic [ADDR_W-1:0] ADDR_RST  = 24'h000000;

   // Instruction-cycle costs of one read, and of the first pair of extended reads in a loop
   localparam int PLAIN_READ_CYC = 1;
   localparam int EXT_READ_CYC   = 2;
   localparam int LOOP_PAIR_CYC  = 3;
   localparam int LOOP_NEXT_CYC  = 1;

   typedef logic [PTR_W-1:0]  esrd_ptr_t;
   typedef logic [PAGE_W-1:0] esrd_page_t;
   typedef logic [ADDR_W-1:0] esrd_addr_t;

   typedef enum logic [1:0] {
      ESRD_IDLE = 2'b00,
      ESRD_OVH  = 2'b01
   } esrd_state_t;

endpackage

// [src/esrd_gen_if.sv]
interface esrd_gen_if;
   import esrd_pkg::*;

   esrd_ptr_t  ptr;
   esrd_page_t page;
   logic       use_ext;
   esrd_addr_t addr;

   modport gen  (input ptr, input page, output use_ext, output addr);
   modport user (output ptr, output page, input use_ext, input addr);
endinterface

// [src/esrd_addr_gen.sv]
module esrd_addr_gen
   import esrd_pkg::*;
(
   esrd_gen_if.gen g   // Pointer in, read address out
);

   always_comb begin
      // Window opens only with the offset top bit set and a low page
      g.use_ext = g.ptr[PTR_TOP_BIT] & ~g.page[PAGE_HI_BIT];
      if (g.use_ext) begin
         g.addr = {g.page[PAGE_LOW_W-1:0], g.ptr[OFS_W-1:0]};
      end else begin
         g.addr = {PLAIN_PAD, g.ptr};
      end
   end

endmodule

// [src/esrd_read_addr.sv]
// Summary of operation
// - Bit 15 of the offset register set by software, with page bit 9 clear, opens the extended window for that read.
// - An extended read is formed only when the address top bit is one and page bit 9 is zero.
// - The extended address is the low 9 page bits above the low 15 offset bits, 24 bits in all.
// - An extended read outside a hardware loop costs one extra cycle, so it takes two cycles.
// - Inside a hardware loop the first two extended reads take three cycles and each later one one cycle.
module esrd_read_addr
   import esrd_pkg::*;
(
   input  wire logic               clock,              // 40 MHz core clock
   input  wire logic               resetn,             // Sync reset, low
   input  wire logic               rd_req,             // Read request
   input  wire esrd_pkg::esrd_ptr_t effective_address, // Pointer value
   input  wire esrd_pkg::esrd_page_t read_page_register, // Page value
   input  wire logic               loop_active,        // Hardware loop on
   output logic                    rd_ready_r,         // Can take request
   output logic                    rd_done_r,          // Read completes
   output esrd_pkg::esrd_addr_t    rd_addr_r,          // Read address
   output logic                    rd_ext_r            // Extended read
);

   import esrd_pkg::*;

   esrd_gen_if  gen_bus ();
   esrd_state_t state_r;
   logic        loop_seen_r;
   logic        take;
   logic        use_ext;
   logic        long_read;
   esrd_addr_t  next_addr;

   // The page and pointer values come from the core; software sets
   // them up before issuing the read.
   assign gen_bus.ptr  = effective_address;
   assign gen_bus.page = read_page_register;
   assign use_ext      = gen_bus.use_ext;
   assign next_addr    = gen_bus.addr;

   esrd_addr_gen u_gen (
      .g (gen_bus.gen)
   );

   assign take = rd_req & rd_ready_r;

   // Only the first extended read of a loop pays the overhead cycle;
   // later reads reuse the prefetched page path.
   assign long_read = use_ext & ~(loop_active & loop_seen_r);

   always_ff @(posedge clock) begin
      if (!resetn) begin
         state_r <= ESRD_IDLE;
      end else begin
         case (state_r)
            ESRD_IDLE: begin
               if (take && long_read) begin
                  state_r <= ESRD_OVH;
               end
            end
            ESRD_OVH: begin
               state_r <= ESRD_IDLE;
            end
            default: begin
               state_r <= ESRD_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         rd_ready_r <= READY_RST;
      end else begin
         case (state_r)
            ESRD_IDLE: begin
               if (take && long_read) begin
                  rd_ready_r <= 1'b0;
               end
            end
            ESRD_OVH: begin
               rd_ready_r <= 1'b1;
            end
            default: begin
               rd_ready_r <= 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         rd_done_r <= 1'b0;
      end else begin
         case (state_r)
            ESRD_IDLE: begin
               rd_done_r <= take & ~long_read;
            end
            ESRD_OVH: begin
               rd_done_r <= 1'b1;
            end
            default: begin
               rd_done_r <= 1'b0;
            end
         endcase
      end
   end

   // Address stays put until the next accepted read
   always_ff @(posedge clock) begin
      if (!resetn) begin
         rd_addr_r <= ADDR_RST;
         rd_ext_r  <= 1'b0;
      end else if (take) begin
         rd_addr_r <= next_addr;
         rd_ext_r  <= use_ext;
      end
   end

   // Cleared whenever the loop ends, so a new loop pays again
   always_ff @(posedge clock) begin
      if (!resetn) begin
         loop_seen_r <= 1'b0;
      end else if (!loop_active) begin
         loop_seen_r <= 1'b0;
      end else if (take && use_ext) begin
         loop_seen_r <= 1'b1;
      end
   end

   // Helper copies so that $past sees plain signals
   logic [OFS_W-1:0]      ptr_low;
   logic [PAGE_LOW_W-1:0] page_low;
   logic                  ptr_top;
   logic                  page_hi;
   assign ptr_low  = effective_address[OFS_W-1:0];
   assign page_low = read_page_register[PAGE_LOW_W-1:0];
   assign ptr_top  = effective_address[PTR_TOP_BIT];
   assign page_hi  = read_page_register[PAGE_HI_BIT];

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!resetn);

   a_window_open: assert property (
      take && ptr_top && !page_hi |=> rd_ext_r
   ) else $error("window bit set but read not extended");

   a_ext_select: assert property (
      take |=> rd_ext_r == ($past(ptr_top) && !$past(page_hi))
   ) else $error("extended select does not match pointer and page");

   a_ext_addr: assert property (
      take && use_ext |=> rd_addr_r == {$past(page_low), $past(ptr_low)}
   ) else $error("extended address not page over offset");

   a_ext_overhead: assert property (
      take && use_ext && !loop_active
         |=> !rd_done_r && !rd_ready_r ##1 rd_done_r && rd_ready_r
   ) else $error("extended read did not take two cycles");

   a_loop_first: assert property (
      take && use_ext && loop_active && !loop_seen_r
         |=> !rd_done_r ##1 rd_done_r
   ) else $error("first loop read did not take two cycles");

   a_loop_next: assert property (
      take && use_ext && loop_active && loop_seen_r
         |=> rd_done_r && rd_ready_r
   ) else $error("later loop read not single cycle");

   a_plain_read: assert property (
      take && !ptr_top |=> rd_done_r && rd_ready_r && !rd_ext_r
         && rd_addr_r[ADDR_W-1:PTR_W] == PLAIN_PAD
   ) else $error("plain read used page or overhead");

   a_stall_short: assert property (
      !rd_ready_r |=> rd_ready_r
   ) else $error("stall lasted more than one cycle");

   c_plain: cover property (take && !use_ext ##1 rd_done_r);
   c_ext: cover property (take && use_ext && !loop_active ##2 rd_done_r);
   c_loop_pair: cover property (
      take && use_ext && loop_active ##2 take && use_ext && loop_active
         ##1 rd_done_r
   );
   c_back_to_back: cover property (take ##1 take ##1 take);

endmodule

// [bench/esrd_core_model.sv]
module esrd_core_model
   import esrd_pkg::*;
(
   input  wire logic                 clock,              // Core clock
   input  wire logic                 go,                 // Start one read
   input  wire esrd_pkg::esrd_ptr_t  ptr_in,             // Pointer to send
   input  wire esrd_pkg::esrd_page_t pg_in,              // Page to send
   input  wire logic                 rd_ready_r,         // Block can take
   output logic                      rd_req,             // Read request
   output esrd_pkg::esrd_ptr_t       effective_address,  // Pointer out
   output esrd_pkg::esrd_page_t      read_page_register  // Page out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic taken;
   initial begin
      rd_req             = 1'b0;
      effective_address  = 16'h0000;
      read_page_register = 10'h000;
      taken              = 1'b0;
   end
   always @(posedge clock) begin
      taken <= rd_req && rd_ready_r;
   end
   // Pointer and page set up with the request, held until taken
   always @(negedge clock) begin
      if (go) begin
         rd_req             <= 1'b1;
         effective_address  <= ptr_in;
         read_page_register <= pg_in;
      end else if (taken) begin
         // Released lines flip so a stale value cannot pass for a hold
         rd_req             <= 1'b0;
         effective_address  <= ~effective_address;
         read_page_register <= ~read_page_register;
      end
   end
endmodule

// [bench/esrd_read_addr_test.sv]
module esrd_read_addr_test;
   import esrd_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {
      esrd_ptr_t  ptr;
      esrd_page_t pg;
      logic       lp;
      esrd_addr_t addr;
      logic       ext;
      logic [31:0] lat;
   } esrd_row_t;
   logic clock = 1'b0;
   logic resetn = 1'b0;
   logic go = 1'b0;
   logic loop_active = 1'b0;
   esrd_ptr_t ptr_in = 16'h0000;
   esrd_page_t pg_in = 10'h000;
   logic rd_req, rd_ready_r, rd_done_r, rd_ext_r;
   esrd_ptr_t effective_address;
   esrd_page_t read_page_register;
   esrd_addr_t rd_addr_r;
   int bad_count = 0;
   int check_count = 0;
   esrd_row_t rows [10] = '{
      '{16'h0800, 10'h002, 1'b0, 24'h000800, 1'b0, PLAIN_READ_CYC},
      '{16'h8800, 10'h002, 1'b0, 24'h010800, 1'b1, EXT_READ_CYC},
      '{16'hffff, 10'h3ff, 1'b0, 24'h00ffff, 1'b0, PLAIN_READ_CYC},
      '{16'hffff, 10'h1ff, 1'b0, 24'hffffff, 1'b1, EXT_READ_CYC},
      '{16'h8000, 10'h000, 1'b0, 24'h000000, 1'b1, EXT_READ_CYC},
      '{16'h8123, 10'h055, 1'b1, 24'h2a8123, 1'b1, EXT_READ_CYC},
      '{16'h8124, 10'h055, 1'b1, 24'h2a8124, 1'b1, LOOP_NEXT_CYC},
      '{16'h8125, 10'h055, 1'b1, 24'h2a8125, 1'b1, LOOP_NEXT_CYC},
      '{16'h0126, 10'h055, 1'b1, 24'h000126, 1'b0, PLAIN_READ_CYC},
      '{16'h8127, 10'h055, 1'b0, 24'h2a8127, 1'b1, EXT_READ_CYC}};
   always #12.5 clock = ~clock;
   esrd_core_model partner (.clock(clock), .go(go), .ptr_in(ptr_in),
      .pg_in(pg_in), .rd_ready_r(rd_ready_r), .rd_req(rd_req),
      .effective_address(effective_address),
      .read_page_register(read_page_register));
   esrd_read_addr dut (.clock(clock), .resetn(resetn), .rd_req(rd_req),
      .effective_address(effective_address),
      .read_page_register(read_page_register),
      .loop_active(loop_active), .rd_ready_r(rd_ready_r),
      .rd_done_r(rd_done_r), .rd_addr_r(rd_addr_r), .rd_ext_r(rd_ext_r));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask
   task automatic end_sim();
      if (bad_count == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // Latency counted in cycles from the cycle the request goes up
   task automatic issue(input esrd_row_t r);
      int n;
      n = 0;
      @(negedge clock);
      go <= 1'b1;
      ptr_in <= r.ptr;
      pg_in <= r.pg;
      loop_active <= r.lp;
      @(negedge clock);
      go <= 1'b0;
      do begin
         @(negedge clock);
         n++;
      end while (rd_done_r !== 1'b1 && n < 8);
      if (n >= 8) begin
         check(0, 1);
         end_sim();
      end
      check(n, r.lat);
      check(rd_addr_r, r.addr);
      check(rd_ext_r, r.ext);
   endtask
   task automatic reset_check();
      resetn <= 1'b0;
      repeat (4) @(negedge clock);
      resetn <= 1'b1;
      check({rd_ready_r, rd_done_r, rd_ext_r}, 3'b100);
      check(rd_addr_r, 24'h000000);
   endtask
   initial begin
      reset_check();
      foreach (rows[i]) begin
         issue(rows[i]);
      end
      // Loop memory set, then a reset with the loop still on clears it
      issue(rows[5]);
      reset_check();
      issue(rows[5]);
      end_sim();
   end
endmodule
